// file: stfp_pkg.sv
package stfp_pkg;

    // Main clock period; the link loss cycle count below is derived from it.
    localparam int CLK_PERIOD_NS = 50;

    // Register addresses, demultiplexed host bus (4-bit space, bank by bank_select).
    localparam logic [5:0] ADDR_OPMODE_DEMUX = 6'h0f;
    localparam logic [5:0] ADDR_VERSION_DEMUX = 6'h0d;
    localparam logic [5:0] ADDR_MEMCMD_DEMUX = 6'h0c;
    localparam logic [5:0] ADDR_FORMAT_DEMUX = 6'h0e;

    // Register addresses, multiplexed host bus (no banking).
    localparam logic [5:0] ADDR_OPMODE_MUX_A = 6'h1e;
    localparam logic [5:0] ADDR_OPMODE_MUX_B = 6'h3e;
    localparam logic [5:0] ADDR_VERSION_MUX = 6'h3a;
    localparam logic [5:0] ADDR_MEMCMD_MUX = 6'h38;
    localparam logic [5:0] ADDR_FORMAT_MUX = 6'h3c;

    // Field positions in operation_mode.
    localparam int OMS_HI = 7;
    localparam int OMS_LO = 6;
    localparam int DRIVER_TYPE_BIT = 3;
    localparam int MON_HS_BIT = 2;
    localparam int STANDBY_BIT = 1;
    localparam int BANK_BIT = 0;
    localparam logic [7:0] OPMODE_RESET = 8'h00;

    // Field positions in version_status.
    localparam int INIT_FLAG_BIT = 7;
    localparam logic INIT_FLAG_RESET = 1'b1;

    // Field positions in port_format.
    localparam int CHAN_HI = 1;
    localparam int CHAN_LO = 0;
    localparam int HALF_DUPLEX_BIT = 2;
    localparam int SWAP_LANES_BIT = 3;
    localparam int DIV_HI = 7;
    localparam int DIV_LO = 4;
    localparam logic [7:0] FORMAT_RESET = 8'h02;

    // Channel count codes and resulting last bit index of the frame.
    localparam logic [1:0] CHAN_ONE = 2'b00;
    localparam logic [1:0] CHAN_THREE = 2'b01;
    localparam logic [7:0] LAST_BIT_ONE = 8'h1f;
    localparam logic [7:0] LAST_BIT_THREE = 8'h5f;
    localparam logic [7:0] LAST_BIT_EIGHT = 8'hff;

    // Bit positions inside a 32-bit channel for the control bits of slot four.
    localparam logic [4:0] CTRL_BIT_A = 5'h1e;
    localparam logic [4:0] CTRL_BIT_B = 5'h1f;

    // Operating modes.
    typedef enum logic [1:0]
    {
        MODE_CM_RESET = 2'b00,
        MODE_TEST = 2'b01,
        MODE_CM_INIT = 2'b10,
        MODE_NORMAL = 2'b11
    } stfp_mode_type;

    // Control memory reset command nibble and the length of the clear sweep.
    localparam logic [3:0] CM_RESET_CMD = 4'h7;
    localparam logic [8:0] CM_CLEAR_CYCLES = 9'h100;

    // Link clock loss detection time and its cycle count (rounded down).
    localparam int LINK_LOSS_NS = 3200;
    localparam logic [7:0] LINK_LOSS_CYCLES = 8'(LINK_LOSS_NS / CLK_PERIOD_NS);

endpackage : stfp_pkg

// file: stfp_frame_timer.sv
module stfp_frame_timer
(
    input wire logic link_clk_in, // Link reference clock.
    input wire logic rst_b_in, // Asynchronous reset, active low.
    input wire logic [3:0] half_period_in, // Link cycles per clock half, minus one.
    input wire logic [7:0] last_bit_in, // Index of the last bit of the frame.
    input wire logic half_duplex_in, // Line bus framing when high.
    output logic dcl_out, // Double-rate data clock.
    output logic fsc_out, // Frame sync or direction signal.
    output logic [7:0] bit_index_out, // Bit position in the frame.
    output logic bit_start_out, // Pulse at the start of each bit.
    output logic sample_out, // Pulse in the middle of each bit.
    output logic upstream_half_out // High in the second frame half of line bus framing.
);
    import stfp_pkg::*;

    logic [3:0] div_cnt;
    logic [1:0] phase;
    logic [7:0] bit_index;
    wire div_end = (div_cnt >= half_period_in);
    wire bit_end = div_end && (phase == 2'b11);
    wire [7:0] next_bit_index = (bit_end && bit_index >= last_bit_in) ? 8'h00 :
                                bit_end ? bit_index + 8'h01 : bit_index;
    wire [1:0] next_phase = div_end ? phase + 2'b01 : phase;
    wire [7:0] half_point = {1'b0, last_bit_in[7:1]};
    // Line bus: direction high for the first half; otherwise a one-bit sync pulse.
    wire next_fsc = half_duplex_in ? (next_bit_index <= half_point) : (next_bit_index == 8'h00);

    // Each bit spans two clock periods, i.e. four halves, so the clock is twice the bit rate.
    always_ff @(posedge link_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            div_cnt <= 4'h0;
            phase <= 2'b00;
            bit_index <= 8'h00;
        end
        else
        begin
            div_cnt <= div_end ? 4'h0 : div_cnt + 4'h1;
            phase <= next_phase;
            bit_index <= next_bit_index;
        end
    end

    // Registered outputs so the pins never see decode glitches.
    always_ff @(posedge link_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            dcl_out <= 1'b1;
            fsc_out <= 1'b1;
            bit_index_out <= 8'h00;
            bit_start_out <= 1'b0;
            sample_out <= 1'b0;
            upstream_half_out <= 1'b0;
        end
        else
        begin
            dcl_out <= ~next_phase[0];
            fsc_out <= next_fsc;
            bit_index_out <= next_bit_index;
            bit_start_out <= bit_end;
            sample_out <= div_end && (phase == 2'b01);
            upstream_half_out <= half_duplex_in && (next_bit_index > half_point);
        end
    end

endmodule : stfp_frame_timer

// file: stfp_port.sv
// What this block does
// - Driver-type bit: 0 tristate, 1 open-drain.
// - Monitor handshake bit: 0 off, 1 on.
// - Standby 0 floats data, clock, sync outputs.
// - Bank select steers demultiplexed register accesses.
// - Version register: no interrupt, read harmless.
// - Clock loss or power failure sets init request.
// - Only memory reset command clears init request.
// - Version layout: flag, zeros, version nibble.
// - Channel is four byte slots per frame.
// - Command/indication repeated every frame while valid; the bit source does this, not the block.
// - Acknowledge bit accompanies one-byte monitor messages.
// - Single channel: 256 kbit/s, 512 kHz clock.
// - Multiplexed: eight channels, 4.096 MHz clock.
// - Enhanced formats: clock twice bit rate, sync.
// - Enhanced line card: eight channels, handshaked monitor.
// - Terminal format: three channels, 1536 kHz clock.
// - Line bus: device masters clock and direction.
// - Direction high downstream, low upstream.
// - Line bus byte roles: user, feature, signaling; set by the bit source, not the block.
// - No single format bit; settings compose formats.
// - Memory reset mode stops port operation.
module stfp_port
#(
    parameter logic [3:0] CHIP_VERSION = 4'h5 // Arbitrary value.
)
(
    input wire logic clk_in, // Main clock, 20 MHz.
    input wire logic rst_b_in, // Asynchronous reset, active low.
    input wire logic link_clk_in, // Link reference clock.
    input wire logic mux_mode_in, // Host bus multiplexed when high.
    input wire logic cs_b_in, // Host chip select, active low.
    input wire logic rd_b_in, // Host read strobe, active low.
    input wire logic wr_b_in, // Host write strobe, active low.
    input wire logic [5:0] addr_in, // Host register address.
    input wire logic [7:0] data_in, // Host data bus, input side.
    output logic [7:0] data_out, // Host data bus, output side.
    output logic data_oe_out, // Host data bus drive enable.
    input wire logic power_fail_in, // Power failure indication.
    input wire logic [3:0] ds_data_in, // Downstream bit per lane, link domain.
    input wire logic ack_in, // Monitor acknowledge bit, link domain.
    input wire logic hs_rx_in, // Monitor receive handshake, link domain.
    input wire logic hs_tx_in, // Monitor transmit handshake, link domain.
    output logic [7:0] bit_index_out, // Frame bit position, link domain.
    output logic bit_request_out, // Next downstream bit wanted, pulse.
    input wire logic [3:0] dd_in, // Downstream lane pins, input side.
    output logic [3:0] dd_out, // Downstream lane pins, output side.
    output logic [3:0] dd_oe_out, // Downstream lane pins, drive enable.
    input wire logic [3:0] du_in, // Upstream lane pins, input side.
    output logic [3:0] du_out, // Upstream lane pins, output side.
    output logic [3:0] du_oe_out, // Upstream lane pins, drive enable.
    output logic dcl_out, // Double-rate data clock pin.
    output logic dcl_oe_out, // Data clock pin drive enable.
    output logic fsc_out, // Frame sync or direction pin.
    output logic fsc_oe_out, // Frame sync pin drive enable.
    output logic [3:0] rx_data_out, // Received bit per lane, link domain.
    output logic rx_valid_out // Received bits valid, pulse.
);
    import stfp_pkg::*;

    // Host bus pins are asynchronous to clk_in; two stages before any use.
    logic [16:0] bus_meta;
    logic [16:0] bus_sync;
    logic wr_active_d;
    logic [2:0] misc_meta;
    logic [2:0] misc_sync;
    logic link_seen_d;
    logic [7:0] operation_mode;
    logic [7:0] port_format;
    logic init_request_flag;
    logic [8:0] clear_cnt;
    logic [7:0] loss_cnt;
    logic link_lost;

    wire [5:0] bus_addr = bus_sync[5:0];
    wire [7:0] bus_data = bus_sync[13:6];
    wire bus_cs = ~bus_sync[14];
    wire bus_rd = bus_cs && ~bus_sync[15];
    wire bus_wr = bus_cs && ~bus_sync[16];
    wire wr_commit = wr_active_d && !bus_wr;
    wire is_mux = misc_sync[0];
    wire power_fail = misc_sync[1];
    wire link_seen = misc_sync[2];

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bus_meta <= 17'h1c000;
            bus_sync <= 17'h1c000;
            wr_active_d <= 1'b0;
        end
        else
        begin
            bus_meta <= {wr_b_in, rd_b_in, cs_b_in, data_in, addr_in};
            bus_sync <= bus_meta;
            wr_active_d <= bus_wr;
        end
    end

    // Address decode; the bank only matters on the demultiplexed bus.
    wire bank_select = operation_mode[BANK_BIT];
    wire sel_opmode = is_mux ? (bus_addr == ADDR_OPMODE_MUX_A || bus_addr == ADDR_OPMODE_MUX_B)
                             : (bus_addr == ADDR_OPMODE_DEMUX);
    wire sel_version = is_mux ? (bus_addr == ADDR_VERSION_MUX)
                              : (bus_addr == ADDR_VERSION_DEMUX && bank_select);
    wire sel_memcmd = is_mux ? (bus_addr == ADDR_MEMCMD_MUX)
                             : (bus_addr == ADDR_MEMCMD_DEMUX && bank_select);
    wire sel_format = is_mux ? (bus_addr == ADDR_FORMAT_MUX)
                             : (bus_addr == ADDR_FORMAT_DEMUX && bank_select);

    // Version register is a pure view; reading it has no side effects.
    wire [7:0] version_status = {init_request_flag, 3'b000, CHIP_VERSION};
    wire [7:0] read_mux = sel_opmode ? operation_mode :
                          sel_version ? version_status :
                          sel_format ? port_format : 8'h00;

    // Read data is re-registered every cycle while the strobe is held.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            data_out <= 8'h00;
            data_oe_out <= 1'b0;
        end
        else
        begin
            data_out <= read_mux;
            data_oe_out <= bus_rd;
        end
    end

    // Writes commit when the write strobe ends, so address and data have settled.
    // All format choices are separate fields; there is no single format bit.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            operation_mode <= OPMODE_RESET;
            port_format <= FORMAT_RESET;
        end
        else
        begin
            if (wr_commit && sel_opmode)
                operation_mode <= bus_data;
            if (wr_commit && sel_format)
                port_format <= bus_data;
        end
    end

    // Memory reset command: accepted only in reset mode with command nibble 7.
    wire [1:0] oms_bits = operation_mode[OMS_HI:OMS_LO];
    wire in_cm_reset = (oms_bits == MODE_CM_RESET);
    wire clear_busy = (clear_cnt != 9'h000);
    wire clear_start = wr_commit && sel_memcmd && in_cm_reset
                       && (bus_data[7:4] == CM_RESET_CMD) && !clear_busy;
    wire clear_done = (clear_cnt == 9'h001);

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            clear_cnt <= 9'h000;
        else if (clear_start)
            clear_cnt <= CM_CLEAR_CYCLES;
        else if (clear_busy)
            clear_cnt <= clear_cnt - 9'h001;
    end

    // Mode strap, power failure and the link activity toggle cross in two stages.
    logic link_toggle;
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            misc_meta <= 3'b000;
            misc_sync <= 3'b000;
            link_seen_d <= 1'b0;
        end
        else
        begin
            misc_meta <= {link_toggle, power_fail_in, mux_mode_in};
            misc_sync <= misc_meta;
            link_seen_d <= link_seen;
        end
    end

    // A stalled link clock is improper clocking; it is flagged after a fixed quiet time.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            loss_cnt <= 8'h00;
            link_lost <= 1'b0;
        end
        else if (link_seen != link_seen_d)
        begin
            loss_cnt <= 8'h00;
            link_lost <= 1'b0;
        end
        else if (loss_cnt >= LINK_LOSS_CYCLES)
            link_lost <= 1'b1;
        else
            loss_cnt <= loss_cnt + 8'h01;
    end

    // Set beats clear: a fault during the final sweep cycle keeps the flag raised.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            init_request_flag <= INIT_FLAG_RESET;
        else if (power_fail || link_lost)
            init_request_flag <= 1'b1;
        else if (clear_done)
            init_request_flag <= 1'b0;
    end

    // The port runs only in normal or test mode, out of standby and not clearing.
    wire port_enable = operation_mode[STANDBY_BIT]
                       && (oms_bits == MODE_NORMAL || oms_bits == MODE_TEST)
                       && !clear_busy;
    wire [10:0] cfg_main = {port_enable, operation_mode[MON_HS_BIT], operation_mode[DRIVER_TYPE_BIT], port_format};

    // Link domain. Configuration is quasi-static, so a two-stage level crossing suffices.
    logic [10:0] cfg_meta;
    logic [10:0] cfg_link;
    logic [3:0] dd_meta;
    logic [3:0] dd_sync;
    logic [3:0] du_meta;
    logic [3:0] du_sync;

    always_ff @(posedge link_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cfg_meta <= 11'h000;
            cfg_link <= 11'h000;
            dd_meta <= 4'h0;
            dd_sync <= 4'h0;
            du_meta <= 4'h0;
            du_sync <= 4'h0;
            link_toggle <= 1'b0;
        end
        else
        begin
            cfg_meta <= cfg_main;
            cfg_link <= cfg_meta;
            dd_meta <= dd_in;
            dd_sync <= dd_meta;
            du_meta <= du_in;
            du_sync <= du_meta;
            link_toggle <= ~link_toggle;
        end
    end

    wire link_enable = cfg_link[10];
    wire mon_handshake_select = cfg_link[9];
    wire output_driver_type = cfg_link[8];
    wire [1:0] chan_code = cfg_link[CHAN_HI:CHAN_LO];
    wire half_duplex = cfg_link[HALF_DUPLEX_BIT];
    wire swap_lanes = cfg_link[SWAP_LANES_BIT];
    wire [3:0] half_period = cfg_link[DIV_HI:DIV_LO];
    // One, three or eight channels of four byte slots each.
    wire [7:0] last_bit = (chan_code == CHAN_ONE) ? LAST_BIT_ONE :
                          (chan_code == CHAN_THREE) ? LAST_BIT_THREE : LAST_BIT_EIGHT;

    logic tmr_dcl;
    logic tmr_fsc;
    logic [7:0] tmr_index;
    logic tmr_bit_start;
    logic tmr_sample;
    logic tmr_up_half;

    // Rate follows the programmed divider; clock is twice the bit rate in every format.
    stfp_frame_timer u_timer
    (
        .link_clk_in(link_clk_in),
        .rst_b_in(rst_b_in),
        .half_period_in(half_period),
        .last_bit_in(last_bit),
        .half_duplex_in(half_duplex),
        .dcl_out(tmr_dcl),
        .fsc_out(tmr_fsc),
        .bit_index_out(tmr_index),
        .bit_start_out(tmr_bit_start),
        .sample_out(tmr_sample),
        .upstream_half_out(tmr_up_half)
    );

    // Slot-four control bits: handshake pair when enabled, else acknowledge bit.
    // Command/indication repetition and line bus byte roles come from the bit source.
    wire at_ctrl_a = (tmr_index[4:0] == CTRL_BIT_A);
    wire at_ctrl_b = (tmr_index[4:0] == CTRL_BIT_B);
    wire drive_phase = link_enable && !(half_duplex && tmr_up_half);

    // Per-lane drivers; open-drain only pulls low, tristate drives both levels.
    logic [3:0] lane_out;
    logic [3:0] lane_oe;
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_lane
            wire raw_bit = ds_data_in[i];
            wire ctrl_a = mon_handshake_select ? hs_rx_in : ack_in;
            wire ctrl_b = mon_handshake_select ? hs_tx_in : raw_bit;
            wire tx_bit = at_ctrl_a ? ctrl_a : at_ctrl_b ? ctrl_b : raw_bit;
            // Disabled lanes float whatever the driver type.
            assign lane_out[i] = output_driver_type ? 1'b0 : tx_bit;
            assign lane_oe[i] = drive_phase && (output_driver_type ? !tx_bit : 1'b1);
        end
    endgenerate

    // Bits change once per bit time while driving; reloaded every cycle while released.
    always_ff @(posedge link_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            dd_out <= 4'h0;
            dd_oe_out <= 4'h0;
            du_out <= 4'h0;
            du_oe_out <= 4'h0;
        end
        else if (tmr_bit_start || !drive_phase)
        begin
            dd_out <= swap_lanes ? 4'h0 : lane_out;
            dd_oe_out <= swap_lanes ? 4'h0 : lane_oe;
            du_out <= swap_lanes ? lane_out : 4'h0;
            du_oe_out <= swap_lanes ? lane_oe : 4'h0;
        end
    end

    // Clock and sync pins float in standby; device is master of both.
    always_ff @(posedge link_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            dcl_out <= 1'b1;
            dcl_oe_out <= 1'b0;
            fsc_out <= 1'b0;
            fsc_oe_out <= 1'b0;
        end
        else
        begin
            dcl_out <= tmr_dcl;
            dcl_oe_out <= link_enable;
            fsc_out <= tmr_fsc;
            fsc_oe_out <= link_enable;
        end
    end

    // Receive: on the line bus the shared wire is read in the upstream half.
    wire [3:0] rx_lane = (half_duplex ? !swap_lanes : swap_lanes) ? dd_sync : du_sync;
    wire rx_take = link_enable && tmr_sample && (!half_duplex || tmr_up_half);

    always_ff @(posedge link_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_data_out <= 4'h0;
            rx_valid_out <= 1'b0;
            bit_index_out <= 8'h00;
            bit_request_out <= 1'b0;
        end
        else
        begin
            if (rx_take)
                rx_data_out <= rx_lane;
            rx_valid_out <= rx_take;
            bit_index_out <= tmr_index;
            bit_request_out <= tmr_bit_start && drive_phase;
        end
    end

endmodule : stfp_port

// file: stfp_port_props.sv
module stfp_port_props
#(
    parameter logic [3:0] CHIP_VERSION = 4'h5 // Arbitrary value.
)
(
    input wire logic clk_in, // Main clock.
    input wire logic rst_b_in, // Reset.
    input wire logic link_clk_in, // Link clock.
    input wire logic mux_mode_in, // Address mode.
    input wire logic cs_b_in, // Select.
    input wire logic rd_b_in, // Read.
    input wire logic [5:0] addr_in, // Address.
    input wire logic [7:0] data_out, // Read data.
    input wire logic data_oe_out, // Read enable.
    input wire logic [3:0] dd_out, // Down lanes.
    input wire logic [3:0] dd_oe_out, // Down enables.
    input wire logic [3:0] du_out, // Up lanes.
    input wire logic [3:0] du_oe_out, // Up enables.
    input wire logic bit_request_out, // Bit pulse.
    input wire logic rx_valid_out // Receive pulse.
);
    import stfp_pkg::*;
    // A lane driven high means push-pull drive, so every driving lane is enabled.
    dd_kind_a: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
        |(dd_out & dd_oe_out) |-> &dd_oe_out) else $error("Down lanes mix kinds.");
    du_kind_a: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
        |(du_out & du_oe_out) |-> &du_oe_out) else $error("Up lanes mix kinds.");
    // A bit lasts at least four link cycles.
    req_pulse_a: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
        bit_request_out |=> !bit_request_out [*3]) else $error("Bit pulse too close.");
    rx_pulse_a: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
        rx_valid_out |=> !rx_valid_out [*3]) else $error("Receive pulse too close.");
    // Host reads: the strobes pass two synchronisers and a register.
    read_on_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!cs_b_in && !rd_b_in) [*4] |=> data_oe_out) else $error("Read not answered.");
    read_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (cs_b_in && rd_b_in) [*4] |=> !data_oe_out) else $error("Bus held after read.");
    version_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!cs_b_in && !rd_b_in && mux_mode_in && addr_in == ADDR_VERSION_MUX) [*5]
        |=> data_out[6:0] == {3'h0, CHIP_VERSION}) else $error("Status layout wrong.");
    unmapped_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!cs_b_in && !rd_b_in && addr_in == 6'h00) [*5] |=> data_out == 8'h00)
        else $error("Empty address not zero.");
endmodule : stfp_port_props

// file: stfp_line_model.sv
module stfp_line_model
(
    input wire logic dcl_in, // Data clock on the bus.
    input wire logic fsc_in, // Direction signal.
    input wire logic fsc_en_in, // Direction signal driven.
    output logic [3:0] en_out, // Lane drive enable.
    output logic [3:0] d_out // Lane drive value.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Silent at start; a released lane rests on its pull-up.
    initial {en_out, d_out} = 8'h09;
    // Answers while direction is low; the level flips each frame, so stale data shows.
    always @(negedge dcl_in)
    begin
        en_out <= {4{fsc_en_in & ~fsc_in}};
    end
    always @(negedge fsc_in) d_out <= ~d_out;
endmodule : stfp_line_model

// file: stfp_port_tb.sv
module stfp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import stfp_pkg::*;
    localparam logic [3:0] CHIP_VERSION = 4'h3; // Arbitrary value.
    logic clk_in = 1'b0, link_clk_in = 1'b0, rst_b_in = 1'b0;
    logic mux_mode_in, cs_b_in, rd_b_in, wr_b_in, power_fail_in, ack_in, hs_rx_in, hs_tx_in;
    logic data_oe_out, bit_request_out, dcl_out, dcl_oe_out, fsc_out, fsc_oe_out, rx_valid_out;
    logic [5:0] addr_in;
    logic [7:0] data_in, data_out, bit_index_out, rdata, cfg, last;
    logic [3:0] ds_data_in, dd_in, dd_out, dd_oe_out, du_in, du_out, du_oe_out, rx_data_out, m_en, m_d;
    logic [8:0] snap, per;
    int failures = 0, tests_run = 0, cycles = 0;
    // Unrelated clocks; the link clock never stops, so loss detection stays quiet.
    always #25 clk_in = ~clk_in;
    always #40 link_clk_in = ~link_clk_in;
    // Lanes carry pull-ups, so a released lane reads high.
    wire [3:0] m_lvl = (m_en & m_d) | ~m_en;
    assign dd_in = (dd_oe_out & dd_out) | (~dd_oe_out & m_lvl);
    assign du_in = (du_oe_out & du_out) | (~du_oe_out & m_lvl);
    stfp_port #(.CHIP_VERSION(CHIP_VERSION)) i_dut (.*);
    stfp_line_model i_line (.dcl_in(dcl_out | ~dcl_oe_out), .fsc_in(fsc_out),
        .fsc_en_in(fsc_oe_out), .en_out(m_en), .d_out(m_d));
    // Watchdog against a hang in any wait.
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One host access; strobes outlast the synchronisers on both edges.
    task automatic host(input logic [5:0] a, input logic [7:0] d, input logic rd);
        @(posedge clk_in);
        #2;
        {addr_in, data_in, cs_b_in, rd_b_in, wr_b_in} = {a, d, 1'b0, ~rd, rd};
        repeat (5) @(posedge clk_in);
        #2;
        rdata = data_out;
        {cs_b_in, rd_b_in, wr_b_in} = 3'h7;
        repeat (4) @(posedge clk_in);
        #2;
    endtask : host
    // Waits for a fresh bit, snaps the pins at its third falling clock edge and counts its length.
    task automatic bit_at(input logic [7:0] idx);
        while (bit_index_out === idx) @(negedge link_clk_in);
        while (bit_index_out !== idx) @(negedge link_clk_in);
        per = 9'h0;
        while (bit_index_out === idx)
        begin
            @(negedge link_clk_in);
            per++;
            if (per == 9'h2) snap = {fsc_out, dd_oe_out, dd_out};
        end
    endtask : bit_at
    // Expected {enables, levels} of the lanes for one bit per lane.
    function automatic logic [7:0] lane_exp(input logic od, input logic [3:0] v);
        return od ? {~v, 4'h0} : {4'hf, v};
    endfunction : lane_exp
    initial
    begin
        {mux_mode_in, power_fail_in, ack_in, hs_rx_in, hs_tx_in} = 5'b10100;
        {cs_b_in, rd_b_in, wr_b_in, addr_in, data_in, ds_data_in} = {3'h7, 18'h0};
        void'($urandom(32'h15c0));
        repeat (8) @(posedge clk_in);
        #2 rst_b_in = 1'b1;
        // Status after reset, read twice; a write and a wrong command leave it alone.
        host(ADDR_VERSION_MUX, 8'h00, 1'b1);
        chk(rdata, {1'b1, 3'h0, CHIP_VERSION});
        host(ADDR_VERSION_MUX, 8'($urandom), 1'b0);
        host(ADDR_MEMCMD_MUX, 8'h60, 1'b0);
        repeat (300) @(posedge clk_in);
        host(ADDR_VERSION_MUX, 8'h00, 1'b1);
        chk(rdata, {1'b1, 3'h0, CHIP_VERSION});
        // Memory reset clears the flag; a power failure raises it again.
        for (int i = 0; i < 2; i++)
        begin
            host(ADDR_MEMCMD_MUX, {4'h7, 4'($urandom)}, 1'b0);
            repeat (300) @(posedge clk_in);
            host(ADDR_VERSION_MUX, 8'h00, 1'b1);
            chk(rdata, {1'b0, 3'h0, CHIP_VERSION});
            power_fail_in = 1'b1;
            repeat (10) @(posedge clk_in);
            #2 power_fail_in = 1'b0;
            host(ADDR_VERSION_MUX, 8'h00, 1'b1);
            chk(rdata, {1'b1, 3'h0, CHIP_VERSION});
        end
        // An empty address reads zero; the bank bit steers the demultiplexed space.
        host(6'h00, 8'h00, 1'b1);
        chk(rdata, 9'h000);
        mux_mode_in = 1'b0;
        for (int b = 1; b >= 0; b--)
        begin
            host(ADDR_OPMODE_DEMUX, 8'(b), 1'b0);
            host(ADDR_OPMODE_DEMUX, 8'h00, 1'b1);
            chk(rdata, 9'(b));
            host(ADDR_VERSION_DEMUX, 8'h00, 1'b1);
            chk(rdata, b ? {1'b1, 3'h0, CHIP_VERSION} : 8'h00);
        end
        mux_mode_in = 1'b1;
        // In standby nothing drives, even with the open-drain driver kind chosen.
        host(ADDR_OPMODE_MUX_A, 8'hc8, 1'b0);
        repeat (20) @(posedge link_clk_in);
        chk({dcl_oe_out, dd_oe_out, du_oe_out}, 9'h000);
        // Channel counts, clock rates, driver kinds, handshake and line bus in turn.
        for (int i = 0; i < 4; i++)
        begin
            cfg = {4'($urandom % 3), 1'b0, i == 3, (i == 3) ? 2'b00 : 2'(i)};
            last = (cfg[1:0] == 2'b00) ? 8'h1f : (cfg[1:0] == 2'b01) ? 8'h5f : 8'hff;
            #2 ds_data_in = 4'($urandom);
            host(ADDR_FORMAT_MUX, cfg, 1'b0);
            host(ADDR_OPMODE_MUX_B, {4'hc, i[1], i[0], 2'b10}, 1'b0);
            repeat (4) @(posedge link_clk_in);
            bit_at(8'h05);
            chk(per, 9'(4 * (cfg[7:4] + 1)));
            chk(snap, {i == 3, lane_exp(i[1], ds_data_in)});
            if (i != 3) bit_at(8'h1e);
            if (i != 3) chk(snap, {1'b0, lane_exp(i[1], {4{~i[0]}})});
            bit_at(last);
            chk({snap[8], bit_index_out}, 9'h000);
            chk(rx_data_out, m_d);
        end
        finish_test();
    end
endmodule : stfp_port_tb
// Checker on every instance of the port.
bind stfp_port stfp_port_props #(.CHIP_VERSION(CHIP_VERSION)) i_props (.*);
